/* File: logic/clwd_comm_link_watchdog.v */
// Purpose: Idle-gap end of message, framing select and two link watchdogs
// Assumes: Synchronous register port, one-cycle strobes from the link logic
// Notes:   Settings are captured into working copies only on control reset
// Functional notes
// - Link message ends after idle gap of 1 to 10000 ms, default 2; the code takes 0 as 1 and uses values above 10000 as written.
// - Nonzero link timeout in 0.1 s steps raises link alarm without legal message.
// - Framing code: 0 none/1 stop, 1 none/2 stop, 2 even, 3 odd.
// - Saved settings act only after power-up or control board reset.
// - Fieldbus alarm when no legal write within fieldbus timeout in ms.
// - Fieldbus timeout zero disables alarm; default zero.
// - Fieldbus watchdog arms only after first legal message.
// - Alarm clears once timeout is zero and device is reset.
// - Fieldbus alarm suppressed while link data is not used.
// - Config word: node bits 0-7, baud bits 8-11, watchdog type 12-15.
// - Takeover mask: one bit per analog output, set means fieldbus drives it.
// - Fieldbus baud code: 0 125k, 1 250k, 2 500k, 3 automatic.
`timescale 1ns/100ps
`include "clwd_defs.vh"

module clwd_comm_link_watchdog #(
	parameter MS_CYCLES = `CLWD_MS_CYCLES,
	parameter KEY_HOLD_MS = `CLWD_RESET_KEY_S * 1000
) (
	input  wire        sys_clk,
	input  wire        sys_rst,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [11:0] reg_addr,
	input  wire [15:0] reg_wdata,
	output reg  [15:0] reg_rdata,
	output wire        reg_ack,
	input  wire        link1_char_rx,
	output reg         link1_msg_done,
	input  wire        link1_legal_msg,
	output wire [1:0]  link1_parity_mode,
	output wire        link1_two_stop,
	output wire        link1_parity_en,
	output wire        link1_parity_odd,
	input  wire        fb_word_wr,
	input  wire [15:0] fb_word,
	input  wire        fb_profile_mode,
	input  wire        fb_state_ok,
	input  wire        link_data_used,
	input  wire        reset_key,
	input  wire        control_board_reset_cmd,
	output wire [7:0]  fieldbus_node_id,
	output wire [3:0]  fieldbus_bit_rate_code,
	output wire [3:0]  fieldbus_watchdog_type,
	output wire [2:0]  analog_out_takeover,
	output reg         link1_watchdog_alarm,
	output reg         comm_suspended_alarm
);

	// ----------------------------------------
	// Millisecond tick and counters
	// ----------------------------------------
	reg  [17:0] ms_div_q;
	reg         ms_tick_q;
	reg  [15:0] key_cnt_q;
	reg         key_fired_q;
	reg         ctl_reset_q;

	// Saved (written) settings
	reg  [15:0] s_fb_cfg_q;
	reg  [15:0] s_gap_q;
	reg  [15:0] s_l1wdg_q;
	reg  [15:0] s_par_q;
	reg  [15:0] s_fbwdg_q;
	reg  [15:0] s_ao_q;
	reg  [15:0] ip_reset_q;

	// Working settings, loaded at control reset
	reg  [15:0] w_fb_cfg_q;
	reg  [15:0] w_gap_q;
	reg  [23:0] w_l1wdg_ms_q;
	reg  [1:0]  w_par_q;
	reg  [15:0] w_fbwdg_q;
	reg  [2:0]  w_ao_q;

	reg  [15:0] gap_cnt_q;
	reg         gap_run_q;
	reg  [23:0] l1_cnt_q;
	reg  [15:0] fb_cnt_q;
	reg         fb_armed_q;
	reg         fb_last15_q;

	wire        fb_legal;
	wire        fb_legal_bit;

	// Register port answers in the cycle of the strobe
	assign reg_ack = reg_wr | reg_rd;

	// Working outputs
	assign fieldbus_node_id       = w_fb_cfg_q[`CLWD_NODE_MSB:`CLWD_NODE_LSB];
	assign fieldbus_bit_rate_code = w_fb_cfg_q[`CLWD_BAUD_MSB:`CLWD_BAUD_LSB];
	assign fieldbus_watchdog_type = w_fb_cfg_q[`CLWD_WTYPE_MSB:`CLWD_WTYPE_LSB];
	assign analog_out_takeover    = w_ao_q;
	assign link1_parity_mode      = w_par_q;
	assign link1_two_stop         = (w_par_q == `CLWD_PAR_NONE_2S);
	assign link1_parity_en        = w_par_q[1];
	assign link1_parity_odd       = (w_par_q == `CLWD_PAR_ODD_1S);

	// Legal message detection per watchdog type and profile
	assign fb_legal_bit = fb_profile_mode ? fb_word[`CLWD_LEGAL_BIT_PROF]
	                                      : fb_word[`CLWD_LEGAL_BIT_GEN];
	assign fb_legal = fb_word_wr & (
		fb_profile_mode ? fb_legal_bit :
		(fieldbus_watchdog_type == `CLWD_WT_TOGGLE) ? (fb_legal_bit != fb_last15_q) :
		(fieldbus_watchdog_type == `CLWD_WT_STATE)  ? fb_state_ok :
		fb_legal_bit);

	// Next count reaches the limit; shared by the gap and both watchdogs
	// Widened to 24 bits so the longest link timeout cannot wrap
	function clwd_reached;
		input [23:0] cnt;
		input [23:0] lim;
		begin
			clwd_reached = (cnt + 24'h000001) >= lim;
		end
	endfunction

	// ----------------------------------------
	// Millisecond tick and reset key hold
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			ms_div_q    <= 18'h00000;
			ms_tick_q   <= 1'b0;
			key_cnt_q   <= 16'h0000;
			key_fired_q <= 1'b0;
			ctl_reset_q <= 1'b1;
		end else begin
			ms_tick_q <= 1'b0;
			if (ms_div_q == MS_CYCLES[17:0] - 18'h00001) begin
				ms_div_q  <= 18'h00000;
				ms_tick_q <= 1'b1;
			end else begin
				ms_div_q <= ms_div_q + 18'h00001;
			end
			// Key held longer than the hold time gives one reset
			if (!reset_key) begin
				key_cnt_q   <= 16'h0000;
				key_fired_q <= 1'b0;
			end else if (ms_tick_q && !key_fired_q) begin
				key_cnt_q <= key_cnt_q + 16'h0001;
			end
			ctl_reset_q <= 1'b0;
			if (reset_key && !key_fired_q && key_cnt_q > KEY_HOLD_MS[15:0]) begin
				key_fired_q <= 1'b1;
				ctl_reset_q <= 1'b1;
			end
			if (control_board_reset_cmd)
				ctl_reset_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Saved settings written over the port
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			s_fb_cfg_q <= `CLWD_RST_FB_CFG;
			s_gap_q    <= `CLWD_RST_L1_GAP;
			s_l1wdg_q  <= `CLWD_RST_L1_WDG;
			s_par_q    <= `CLWD_RST_L1_PARITY;
			s_fbwdg_q  <= `CLWD_RST_FB_WDG;
			s_ao_q     <= `CLWD_RST_AO_MASK;
			ip_reset_q <= 16'h0000;
		end else if (reg_wr) begin
			case (reg_addr)
			`CLWD_ADDR_FB_CFG:    s_fb_cfg_q <= reg_wdata;
			`CLWD_ADDR_IP_RESET:  ip_reset_q <= reg_wdata;
			`CLWD_ADDR_L1_GAP:    s_gap_q    <= reg_wdata;
			`CLWD_ADDR_L1_WDG:    s_l1wdg_q  <= reg_wdata;
			`CLWD_ADDR_L1_PARITY: s_par_q    <= {14'h0000, reg_wdata[1:0]};
			`CLWD_ADDR_FB_WDG:    s_fbwdg_q  <= reg_wdata;
			`CLWD_ADDR_AO_MASK:   s_ao_q     <= {13'h0000, reg_wdata[2:0]};
			default: ;
			endcase
		end
	end

	// Read mux; unmapped offsets read zero
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
			`CLWD_ADDR_FB_CFG:    reg_rdata <= s_fb_cfg_q;
			`CLWD_ADDR_IP_RESET:  reg_rdata <= ip_reset_q;
			`CLWD_ADDR_L1_GAP:    reg_rdata <= s_gap_q;
			`CLWD_ADDR_L1_WDG:    reg_rdata <= s_l1wdg_q;
			`CLWD_ADDR_L1_PARITY: reg_rdata <= s_par_q;
			`CLWD_ADDR_FB_WDG:    reg_rdata <= s_fbwdg_q;
			`CLWD_ADDR_AO_MASK:   reg_rdata <= s_ao_q;
			`CLWD_ADDR_STATUS:    reg_rdata <= {13'h0000, fb_armed_q,
			                                    comm_suspended_alarm, link1_watchdog_alarm};
			default:              reg_rdata <= 16'h0000;
			endcase
		end
	end

	// ----------------------------------------
	// Working copies loaded at control reset
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			w_fb_cfg_q   <= `CLWD_RST_FB_CFG;
			w_gap_q      <= `CLWD_RST_L1_GAP;
			w_l1wdg_ms_q <= 24'h000000;
			w_par_q      <= `CLWD_PAR_NONE_2S;
			w_fbwdg_q    <= `CLWD_RST_FB_WDG;
			w_ao_q       <= 3'h0;
		end else if (ctl_reset_q) begin
			w_fb_cfg_q   <= s_fb_cfg_q;
			w_gap_q      <= (s_gap_q == 16'h0000) ? 16'h0001 : s_gap_q;
			// Steps of 0.1 s in ms; 60000 steps need 23 bits
			// Product formed at 24 bits so no step count is cut
			w_l1wdg_ms_q <= {8'h00, s_l1wdg_q} * `CLWD_TENTH_S_MS;
			w_par_q      <= s_par_q[1:0];
			w_fbwdg_q    <= s_fbwdg_q;
			w_ao_q       <= s_ao_q[`CLWD_AO_BITS-1:0];
		end
	end

	// ----------------------------------------
	// Idle gap end-of-message detect
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst || ctl_reset_q) begin
			gap_cnt_q      <= 16'h0000;
			gap_run_q      <= 1'b0;
			link1_msg_done <= 1'b0;
		end else begin
			link1_msg_done <= 1'b0;
			if (link1_char_rx) begin
				gap_cnt_q <= 16'h0000;
				gap_run_q <= 1'b1;
			end else if (gap_run_q && ms_tick_q) begin
				// Gap measured in whole ms ticks since the last char
				if (clwd_reached({8'h00, gap_cnt_q}, {8'h00, w_gap_q})) begin
					gap_run_q      <= 1'b0;
					link1_msg_done <= 1'b1;
				end
				gap_cnt_q <= gap_cnt_q + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// Serial link watchdog
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst || ctl_reset_q) begin
			l1_cnt_q             <= 24'h000000;
			link1_watchdog_alarm <= 1'b0;
		end else if (w_l1wdg_ms_q == 24'h000000) begin
			// Zero timeout leaves the link unsupervised
			l1_cnt_q             <= 24'h000000;
			link1_watchdog_alarm <= 1'b0;
		end else if (link1_legal_msg) begin
			l1_cnt_q <= 24'h000000;
		end else if (ms_tick_q && !link1_watchdog_alarm) begin
			l1_cnt_q <= l1_cnt_q + 24'h000001;
			if (clwd_reached(l1_cnt_q, w_l1wdg_ms_q))
				link1_watchdog_alarm <= 1'b1;
		end
	end

	// ----------------------------------------
	// Fieldbus watchdog
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (sys_rst || ctl_reset_q) begin
			fb_cnt_q             <= 16'h0000;
			fb_armed_q           <= 1'b0;
			fb_last15_q          <= 1'b0;
			comm_suspended_alarm <= 1'b0;
		end else begin
			if (fb_word_wr)
				fb_last15_q <= fb_legal_bit;
			if (w_fbwdg_q == 16'h0000 || !link_data_used) begin
				fb_cnt_q             <= 16'h0000;
				comm_suspended_alarm <= 1'b0;
				if (fb_legal)
					fb_armed_q <= 1'b1;
			end else if (fb_legal) begin
				fb_armed_q <= 1'b1;
				fb_cnt_q   <= 16'h0000;
			end else if (fb_armed_q && ms_tick_q && !comm_suspended_alarm) begin
				fb_cnt_q <= fb_cnt_q + 16'h0001;
				// Counting stops once raised; only a control reset, a zero
				// timeout or unused link data brings the alarm back down
				if (clwd_reached({8'h00, fb_cnt_q}, {8'h00, w_fbwdg_q}))
					comm_suspended_alarm <= 1'b1;
			end
		end
	end

endmodule

/* File: logic/clwd_defs.vh */
// Purpose: Constants for the communication link watchdog block
// Assumes: 250 MHz system clock, 16-bit parameter words
// Notes:   Offsets are parameter addresses of the register port
`ifndef CLWD_DEFS_VH
`define CLWD_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CLWD_ADDR_FB_CFG        12'h0e6
`define CLWD_ADDR_IP_RESET      12'h207
`define CLWD_ADDR_L1_GAP        12'h256
`define CLWD_ADDR_L1_WDG        12'h257
`define CLWD_ADDR_L1_PARITY     12'h258
`define CLWD_ADDR_FB_WDG        12'h25b
`define CLWD_ADDR_AO_MASK       12'h25c
`define CLWD_ADDR_STATUS        12'h260

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CLWD_RST_FB_CFG         16'h0000
`define CLWD_RST_L1_GAP         16'h0002
`define CLWD_RST_L1_WDG         16'h0000
`define CLWD_RST_L1_PARITY      16'h0001
`define CLWD_RST_FB_WDG         16'h0000
`define CLWD_RST_AO_MASK        16'h0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CLWD_NODE_LSB           0
`define CLWD_NODE_MSB           7
`define CLWD_BAUD_LSB           8
`define CLWD_BAUD_MSB           11
`define CLWD_WTYPE_LSB          12
`define CLWD_WTYPE_MSB          15
`define CLWD_LEGAL_BIT_GEN      15
`define CLWD_LEGAL_BIT_PROF     11
`define CLWD_AO_BITS            3

// ----------------------------------------
// Encodings
// ----------------------------------------
`define CLWD_PAR_NONE_1S        2'h0
`define CLWD_PAR_NONE_2S        2'h1
`define CLWD_PAR_EVEN_1S        2'h2
`define CLWD_PAR_ODD_1S         2'h3
`define CLWD_BAUD_125K          4'h0
`define CLWD_BAUD_250K          4'h1
`define CLWD_BAUD_500K          4'h2
`define CLWD_BAUD_AUTO          4'h3
`define CLWD_WT_LEVEL           4'h0
`define CLWD_WT_TOGGLE          4'h1
`define CLWD_WT_STATE           4'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLWD_CLK_MHZ            250
`define CLWD_MS_NS              1000000
`define CLWD_CLK_NS             4
`define CLWD_MS_CYCLES          (`CLWD_MS_NS / `CLWD_CLK_NS)
`define CLWD_TENTH_S_MS         24'd100
`define CLWD_RESET_KEY_S        5

`endif

/* File: verif/clwd_link_wdg_assertions.sv */
// Purpose: Concurrent checks on the watchdog block ports
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound from the bench top file
`timescale 1ns/100ps
module clwd_link_wdg_chk #(
	parameter MS_CYCLES = 4
) (
	input wire       sys_clk,
	input wire       sys_rst,
	input wire       link1_char_rx,
	input wire       link1_msg_done,
	input wire [1:0] link1_parity_mode,
	input wire       link1_two_stop,
	input wire       link1_parity_en,
	input wire       link1_parity_odd,
	input wire       link_data_used,
	input wire       reset_key,
	input wire       control_board_reset_cmd,
	input wire [2:0] analog_out_takeover,
	input wire       link1_watchdog_alarm,
	input wire       comm_suspended_alarm
);
	reg       seen_q;
	reg [3:0] hist_q;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// Recent control resets, and end of message seen since last char
	always @(posedge sys_clk) begin
		hist_q <= {hist_q[2:0], sys_rst | reset_key | control_board_reset_cmd};
		if (sys_rst || link1_char_rx)
			seen_q <= 1'b0;
		else if (link1_msg_done)
			seen_q <= 1'b1;
	end
	chk_reset_state: assert property ($fell(sys_rst) |->
		link1_parity_mode == 2'h1 && !link1_watchdog_alarm && !comm_suspended_alarm)
		else $error("reset state wrong");
	chk_frame_decode: assert property (
		{link1_two_stop, link1_parity_en, link1_parity_odd} == (link1_parity_mode == 2'h1 ?
		3'h4 : link1_parity_mode[1] ? {2'h1, link1_parity_mode[0]} : 3'h0))
		else $error("framing decode wrong");
	chk_fb_unused: assert property (
		!link_data_used ##1 !link_data_used |-> !comm_suspended_alarm)
		else $error("alarm while link data unused");
	chk_fb_rise_used: assert property (
		$rose(comm_suspended_alarm) |-> $past(link_data_used))
		else $error("alarm rose while link data unused");
	chk_gap_once: assert property (link1_msg_done |-> !seen_q)
		else $error("second end of message without char");
	chk_done_pulse: assert property (link1_msg_done |=> !link1_msg_done)
		else $error("end of message longer than one cycle");
	chk_link_sticky: assert property ($fell(link1_watchdog_alarm) |-> |hist_q)
		else $error("link alarm cleared without control reset");
	chk_fb_sticky: assert property ($fell(comm_suspended_alarm) |->
		|hist_q || !link_data_used || $past(link_data_used) == 1'b0)
		else $error("fieldbus alarm cleared without reset");
	chk_cfg_held: assert property (
		$changed({analog_out_takeover, link1_parity_mode}) |-> |hist_q)
		else $error("setting changed without control reset");
	cover property (link1_msg_done);
	cover property ($rose(link1_watchdog_alarm));
	cover property ($rose(comm_suspended_alarm));
endmodule

/* File: verif/clwd_master_model.sv */
// Purpose: Fieldbus and serial link master stand-in
// Assumes: Drives just after the rising edge
// Notes:   Idle data lines invert every cycle between writes
`timescale 1ns/100ps
module clwd_master_model (
	input  wire        sys_clk,
	input  wire        fb_en,
	input  wire        link_en,
	input  wire [15:0] legal_bits,
	output reg         fb_word_wr = 1'b0,
	output reg  [15:0] fb_word = 16'h0000,
	output reg         link1_char_rx = 1'b0,
	output reg         link1_legal_msg = 1'b0
);
	reg [7:0] tick_q = 8'h00;
	// Write every 16 cycles, char every 32, legal link message every 256
	always @(posedge sys_clk) begin
		tick_q <= tick_q + 8'h01;
		fb_word_wr <= fb_en && tick_q[3:0] == 4'h0;
		if (fb_en && tick_q[3:0] == 4'h0)
			fb_word <= (16'($urandom) & 16'h77ff) | legal_bits;
		else
			fb_word <= ~fb_word;
		link1_char_rx <= link_en && tick_q[4:0] == 5'h10;
		link1_legal_msg <= link_en && tick_q == 8'h90;
	end
endmodule

/* File: verif/tb_clwd_comm_link_watchdog.sv */
// Purpose: Self-checking bench for the link watchdog
// Assumes: 4 cycles per ms, key hold of 3 ms
// Notes:   Inputs change on the falling edge
`timescale 1ns/100ps
module tb_clwd_comm_link_watchdog;
	reg         sys_clk, sys_rst, reg_wr, reg_rd, reset_key, control_board_reset_cmd;
	reg         fb_profile_mode, link_data_used, fb_en, link_en, fb_state_ok;
	reg  [27:0] rvw;
	reg  [11:0] reg_addr;
	reg  [15:0] reg_wdata, legal_bits, cfg, msk;
	wire [15:0] reg_rdata, fb_word;
	wire [1:0]  link1_parity_mode;
	wire [7:0]  fieldbus_node_id;
	wire [3:0]  fieldbus_bit_rate_code, fieldbus_watchdog_type;
	wire [2:0]  analog_out_takeover;
	wire        reg_ack, link1_char_rx, link1_msg_done, link1_legal_msg, link1_two_stop;
	wire        link1_parity_en, link1_parity_odd, fb_word_wr, link1_watchdog_alarm;
	wire        comm_suspended_alarm;
	wire [4:0]  sig = {fb_word_wr, comm_suspended_alarm, link1_watchdog_alarm,
		link1_msg_done, link1_char_rx};
	integer     failures, total_checks, i, n;
	// Offset and reset value of each readable word, unmapped at 6 and status last
	function [27:0] rv(input integer k);
		case (k)
		0: rv = 28'h0e60000;
		1: rv = 28'h2560002;
		2: rv = 28'h2570000;
		3: rv = 28'h2580001;
		4: rv = 28'h25b0000;
		5: rv = 28'h25c0000;
		7: rv = 28'h2070000;
		8: rv = 28'h2600000;
		default: rv = 28'h1000000;
		endcase
	endfunction
	clwd_comm_link_watchdog #(.MS_CYCLES(4), .KEY_HOLD_MS(3)) i_clwd_comm_link_watchdog (
		.sys_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack,
		.link1_char_rx, .link1_msg_done, .link1_legal_msg, .link1_parity_mode,
		.link1_two_stop, .link1_parity_en, .link1_parity_odd, .fb_word_wr, .fb_word,
		.fb_profile_mode, .fb_state_ok, .link_data_used, .reset_key,
		.control_board_reset_cmd, .fieldbus_node_id, .fieldbus_bit_rate_code,
		.fieldbus_watchdog_type, .analog_out_takeover, .link1_watchdog_alarm,
		.comm_suspended_alarm);
	clwd_master_model i_clwd_master_model (.sys_clk, .fb_en, .link_en, .legal_bits,
		.fb_word_wr, .fb_word, .link1_char_rx, .link1_legal_msg);
	// Clock of 4 ns
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	task give_verdict;
		begin
			$display("checks %0d failures %0d", total_checks, failures);
			if (failures == 0 && total_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task check(input string nm, input logic [15:0] e, input logic [15:0] g);
		begin
			total_checks = total_checks + 1;
			if (g !== e) begin
				failures = failures + 1;
				$display("ERROR %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task cyc(input integer k);
		repeat (k) @(negedge sys_clk);
	endtask
	task acc(input w, input [11:0] a, input [15:0] d);
		begin
			reg_wr = w;
			reg_rd = !w;
			reg_addr = a;
			reg_wdata = d;
			@(posedge sys_clk);
			check("reg_ack", 16'h1, reg_ack);
			cyc(1);
			reg_wr = 1'b0;
			reg_rd = 1'b0;
			cyc(1);
		end
	endtask
	task ctl_rst(input k);
		begin
			reset_key = k;
			control_board_reset_cmd = !k;
			cyc(k ? 32 : 1);
			reset_key = 1'b0;
			control_board_reset_cmd = 1'b0;
			cyc(4);
		end
	endtask
	task wait_sig(input integer sel, input integer lim);
		begin
			n = 0;
			while (sig[sel] !== 1'b1) begin
				if (n >= lim) begin
					failures = failures + 1;
					$display("ERROR wait %0d expected 1 seen 0", sel);
					give_verdict;
				end
				cyc(1);
				n = n + 1;
			end
		end
	endtask
	// Main sequence
	initial begin
		{sys_rst, reg_wr, reg_rd, reset_key, control_board_reset_cmd} = 5'h10;
		{fb_profile_mode, link_data_used, fb_en, link_en} = 4'h4;
		reg_addr = 12'h000;
		reg_wdata = 16'h0000;
		legal_bits = 16'h8000;
		fb_state_ok = 1'b0;
		failures = 0;
		total_checks = 0;
		n = $urandom(32'ha745);
		cyc(12);
		sys_rst = 1'b0;
		cyc(2);
		acc(1, 12'h100, 16'h5a5a);
		for (i = 0; i < 9; i++) begin
			rvw = rv(i);
			acc(0, rvw[27:16], 16'h0000);
			check("reset_val", rvw[15:0], reg_rdata);
		end
		$display("test register defaults done");
		for (i = 0; i < 4; i++) begin
			cfg = {4'(i % 3), 4'(i), 8'($urandom)};
			msk = 16'($urandom);
			acc(1, 12'h258, {msk[15:2], 2'(i)});
			acc(1, 12'h0e6, cfg);
			acc(1, 12'h25c, msk);
			acc(0, 12'h258, 16'h0000);
			check("parity_rd", 16'(i), reg_rdata);
			check("parity_old", 16'(i == 0 ? 1 : i - 1), link1_parity_mode);
			ctl_rst(i[0]);
			check("parity", 16'(i), link1_parity_mode);
			check("fb_cfg", cfg, {fieldbus_watchdog_type, fieldbus_bit_rate_code,
				fieldbus_node_id});
			check("takeover", msk[2:0], analog_out_takeover);
		end
		$display("test settings done");
		acc(1, 12'h256, 16'h0003);
		ctl_rst(0);
		link_en = 1'b1;
		wait_sig(0, 40);
		wait_sig(1, 40);
		check("gap", 16'h1, n >= 8 && n <= 19);
		acc(1, 12'h257, 16'h0001);
		ctl_rst(0);
		cyc(1000);
		check("link_fed", 16'h0, link1_watchdog_alarm);
		link_en = 1'b0;
		wait_sig(2, 420);
		check("link_late", 16'h1, n >= 140);
		link_en = 1'b1;
		ctl_rst(1);
		check("link_clr", 16'h0, link1_watchdog_alarm);
		acc(1, 12'h257, 16'h0000);
		$display("test serial link done");
		acc(1, 12'h25b, 16'h0005);
		ctl_rst(0);
		cyc(200);
		check("fb_unarmed", 16'h0, comm_suspended_alarm);
		fb_en = 1'b1;
		cyc(200);
		check("fb_fed", 16'h0, comm_suspended_alarm);
		wait_sig(4, 20);
		fb_en = 1'b0;
		wait_sig(3, 30);
		check("fb_late", 16'h1, n >= 15 && n <= 23);
		acc(0, 12'h260, 16'h0000);
		check("status", 16'h0006, reg_rdata);
		link_data_used = 1'b0;
		cyc(2);
		check("fb_unused", 16'h0, comm_suspended_alarm);
		link_data_used = 1'b1;
		fb_en = 1'b1;
		cyc(40);
		ctl_rst(0);
		cyc(100);
		check("fb_restored", 16'h0, comm_suspended_alarm);
		fb_en = 1'b0;
		cyc(60);
		check("fb_lost", 16'h1, comm_suspended_alarm);
		acc(1, 12'h25b, 16'h0000);
		ctl_rst(1);
		cyc(100);
		check("fb_off", 16'h0, comm_suspended_alarm);
		$display("test fieldbus done");
		fb_profile_mode = 1'b1;
		acc(1, 12'h25b, 16'h0005);
		ctl_rst(0);
		fb_en = 1'b1;
		cyc(200);
		check("prof_unarmed", 16'h0, comm_suspended_alarm);
		legal_bits = 16'h0800;
		cyc(50);
		fb_en = 1'b0;
		wait_sig(3, 40);
		check("prof_alarm", 16'h1, comm_suspended_alarm);
		$display("test profile done");
		fb_profile_mode = 1'b0;
		legal_bits = 16'h8000;
		acc(1, 12'h0e6, 16'h2000);
		ctl_rst(0);
		fb_en = 1'b1;
		cyc(200);
		check("state_unarmed", 16'h0, comm_suspended_alarm);
		fb_state_ok = 1'b1;
		cyc(50);
		check("state_fed", 16'h0, comm_suspended_alarm);
		fb_state_ok = 1'b0;
		wait_sig(3, 40);
		check("state_lost", 16'h1, comm_suspended_alarm);
		acc(1, 12'h0e6, 16'h1000);
		ctl_rst(0);
		for (i = 0; i < 12; i++) begin
			wait_sig(4, 20);
			legal_bits = legal_bits ^ 16'h8000;
			cyc(1);
		end
		check("toggle_fed", 16'h0, comm_suspended_alarm);
		cyc(60);
		check("toggle_stuck", 16'h1, comm_suspended_alarm);
		fb_en = 1'b0;
		$display("test watchdog types done");
		give_verdict;
	end
endmodule
bind clwd_comm_link_watchdog clwd_link_wdg_chk #(.MS_CYCLES(MS_CYCLES)) i_clwd_link_wdg_chk (
	.sys_clk, .sys_rst, .link1_char_rx, .link1_msg_done, .link1_parity_mode, .link1_two_stop,
	.link1_parity_en, .link1_parity_odd, .link_data_used, .reset_key, .control_board_reset_cmd,
	.analog_out_takeover, .link1_watchdog_alarm, .comm_suspended_alarm);
